// ==== hdl/pwrdn_pkg.sv ====
// Package of constants and types for the serial port powerdown control.
// How it works
// (RULE1) Shutdown override pin low forces powerdown whatever the keep-awake pin says.
// (RULE2) Both control pins high keeps the device active; inactivity powerdown disabled.
// (RULE3) Inactivity powerdown armed only with keep-awake low and shutdown override high.
// (RULE4) Armed and no input edge for 30 seconds powers down pump and transmitters.
// (RULE5) Any transmitter or receiver input edge wakes the device from auto powerdown.
// (RULE6) After any powerdown the timer stays expired until keep-awake rises or edge.
// (RULE7) Keep-awake low: leave manual powerdown only on both pins high or edge.
// (RULE8) Falling keep-awake edge keeps the device active for a full 30 seconds.
// (RULE9) Transmit ability returns within 100 us after powerdown is released.
// (RULE10) Valid flag falls after invalid levels on all receivers exceed 30 us.
// (RULE11) Valid flag rises within 1 us after any receiver shows a valid level.
// (RULE12) Valid flag works in every mode and never changes power state by itself.
// (RULE13) Five-receiver variant disables inverting receiver outputs in manual powerdown.
// (RULE14) Ready falls on powerdown entry, rises when negative rail reaches threshold.
// (RULE15) Valid flag on both pins: down after 30 us invalid, up on valid return.
// (RULE16) Valid flag on override only, keep-awake low: stay down until valid and edge.
// (RULE17) Host may tie both pins together as one shutdown input, disabling auto powerdown.
// (RULE18) In powerdown transmitters are high impedance; receivers stay on except manual case.
// (RULE19) Synchronised edge detectors on every input restart the inactivity timer; here only data pin edges and keep-awake edges or high level restart it.

package pwrdn_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam longint unsigned IDLE_TIME_S = 30;
    localparam longint unsigned IDLE_CYCLES = IDLE_TIME_S * CLK_HZ;
    localparam int unsigned INVALID_TIME_US = 30;
    localparam int unsigned INVALID_CYCLES = INVALID_TIME_US * (CLK_HZ / 1_000_000) + 1;
    localparam int unsigned VALID_TIME_US = 1;
    localparam int unsigned VALID_CYCLES = VALID_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WAKE_TIME_US = 100;
    localparam int unsigned WAKE_CYCLES = WAKE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SYNC_STAGES = 2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0]
    {
        ST_ACTIVE = 2'b00,
        ST_AUTO_DOWN = 2'b01,
        ST_MANUAL_DOWN = 2'b10
    } power_state_t;

    typedef struct packed
    {
        logic tx_enable;
        logic inv_rx_enable;
        logic pump_on;
        logic ready;
    } power_out_t;

    localparam power_out_t POWER_OUT_RESET = '{default: 1'b0};

endpackage : pwrdn_pkg

// ==== hdl/serial_port_powerdown_control.sv ====
// Power state control, idle timer and line-valid detector for a serial transceiver.
`timescale 1ns/1ps
`default_nettype none

module serial_port_powerdown_control #(
    parameter int unsigned NUM_TX = 3,
    parameter int unsigned NUM_RX = 5,
    parameter bit FIVE_RX_VARIANT = 1'b1,
    parameter longint unsigned IDLE_CYCLES = pwrdn_pkg::IDLE_CYCLES,
    parameter int unsigned WAKE_CYCLES = pwrdn_pkg::WAKE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Control pins
    input wire logic shutdown_override_pin_i,
    input wire logic keep_awake_pin_i,
    // Monitored logic inputs and receiver level detectors
    input wire logic [NUM_TX-1:0] tx_data_i,
    input wire logic [NUM_RX-1:0] rx_data_i,
    input wire logic [NUM_RX-1:0] rx_level_valid_i,
    input wire logic neg_rail_ok_i,
    // Status and power outputs
    output logic line_valid_o,
    output logic ready_o,
    output logic pump_on_o,
    output logic tx_enable_o,
    output logic inv_rx_enable_o,
    output logic always_on_receiver_out_enable_o,
    output logic [1:0] power_state_o
);

    localparam int unsigned NIN = NUM_TX + NUM_RX + NUM_RX + 2;
    localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);
    localparam int unsigned LW = $clog2(pwrdn_pkg::INVALID_CYCLES + 1);
    localparam int unsigned WW = $clog2(WAKE_CYCLES + 1);

    // ****************************************************************
    // Input synchronisers and edge detection
    // ****************************************************************
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic [NIN-1:0] sync_prev;
    logic [NIN-1:0] next_sync1;
    logic [NIN-1:0] next_sync2;
    logic [NIN-1:0] next_sync_prev;
    logic [NIN-1:0] edges;
    logic [1:0] settle;
    logic [1:0] next_settle;
    logic warm;
    logic data_edge;
    logic off_n;
    logic awake;
    logic awake_rise;
    logic awake_fall;
    logic [NUM_RX-1:0] lvl_valid;

    always_comb
    begin
        next_sync1 = {shutdown_override_pin_i, keep_awake_pin_i, rx_level_valid_i,
                      rx_data_i, tx_data_i};
        next_sync2 = sync1;
        next_sync_prev = sync2;
        // Edges stay masked until the chain has refilled after reset, so a pin that
        // idles high is not mistaken for activity straight out of reset.
        warm = (settle > 2'(pwrdn_pkg::SYNC_STAGES));
        next_settle = warm ? settle : settle + 2'(1);
        edges = warm ? (sync2 ^ sync_prev) : '0;
        // Only data pins count as activity; pin and level detector changes are separate.
        data_edge = |edges[NUM_TX+NUM_RX-1:0]; // [RULE19]
        lvl_valid = sync2[NUM_TX+NUM_RX +: NUM_RX];
        awake = sync2[NIN-2];
        off_n = sync2[NIN-1];
        awake_rise = edges[NIN-2] & awake;
        awake_fall = edges[NIN-2] & ~awake;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync_prev <= '0;
            settle <= '0;
        end
        else
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sync_prev <= next_sync_prev;
            settle <= next_settle;
        end
    end

    // ****************************************************************
    // Line-valid detector
    // ****************************************************************
    // Runs in every power state and feeds no power decision directly.
    logic [LW-1:0] inv_cnt;
    logic [LW-1:0] next_inv_cnt;
    logic [LW-1:0] val_cnt;
    logic [LW-1:0] next_val_cnt;
    logic line_valid;
    logic next_line_valid;

    always_comb
    begin
        next_inv_cnt = '0;
        next_val_cnt = '0;
        next_line_valid = line_valid; // [RULE12]
        if (|lvl_valid)
        begin
            if (!line_valid)
            begin
                next_val_cnt = val_cnt + LW'(1);
                if (val_cnt >= LW'(pwrdn_pkg::VALID_CYCLES - 1))
                begin
                    next_line_valid = 1'b1; // [RULE11]
                    next_val_cnt = '0;
                end
            end
        end
        else if (line_valid)
        begin
            next_inv_cnt = inv_cnt + LW'(1);
            if (inv_cnt >= LW'(pwrdn_pkg::INVALID_CYCLES - 1))
            begin
                next_line_valid = 1'b0; // [RULE10] [RULE15]
                next_inv_cnt = '0;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            inv_cnt <= '0;
            val_cnt <= '0;
            line_valid <= 1'b0;
        end
        else
        begin
            inv_cnt <= next_inv_cnt;
            val_cnt <= next_val_cnt;
            line_valid <= next_line_valid;
        end
    end

    // ****************************************************************
    // Power state and inactivity timer
    // ****************************************************************
    pwrdn_pkg::power_state_t state;
    pwrdn_pkg::power_state_t next_state;
    logic [IW-1:0] idle_cnt;
    logic [IW-1:0] next_idle_cnt;
    logic expired;
    logic next_expired;
    logic [WW-1:0] wake_cnt;
    logic [WW-1:0] next_wake_cnt;
    logic ready;
    logic next_ready;
    logic armed;

    always_comb
    begin
        armed = off_n & ~awake; // [RULE3]
        next_state = state;
        next_idle_cnt = idle_cnt;
        next_expired = expired;
        next_wake_cnt = wake_cnt;
        next_ready = ready;
        // Timer restart: a data edge, a keep-awake transition or keep-awake held high clears expiry.
        if (data_edge || awake_rise || awake_fall || awake)
        begin
            next_idle_cnt = '0; // [RULE19] [RULE8]
            next_expired = 1'b0;
        end
        else if (!expired)
        begin
            if (idle_cnt >= IW'(IDLE_CYCLES - 1))
            begin
                next_expired = 1'b1;
            end
            else
            begin
                next_idle_cnt = idle_cnt + IW'(1);
            end
        end
        unique case (state)
            pwrdn_pkg::ST_ACTIVE:
            begin
                if (!off_n)
                begin
                    next_state = pwrdn_pkg::ST_MANUAL_DOWN; // [RULE1] [RULE17]
                    next_expired = 1'b1; // [RULE6]
                end
                else if (armed && expired && !data_edge)
                begin
                    next_state = pwrdn_pkg::ST_AUTO_DOWN; // [RULE4]
                end
            end
            pwrdn_pkg::ST_AUTO_DOWN:
            begin
                if (!off_n)
                begin
                    next_state = pwrdn_pkg::ST_MANUAL_DOWN; // [RULE1]
                    next_expired = 1'b1;
                end
                else if (awake || data_edge)
                begin
                    next_state = pwrdn_pkg::ST_ACTIVE; // [RULE5] [RULE2]
                end
            end
            pwrdn_pkg::ST_MANUAL_DOWN:
            begin
                if (off_n && (awake || data_edge))
                begin
                    next_state = pwrdn_pkg::ST_ACTIVE; // [RULE7] [RULE16]
                end
                else if (off_n)
                begin
                    // Override released without activity: timer stays expired.
                    next_state = pwrdn_pkg::ST_AUTO_DOWN; // [RULE6] [RULE16]
                    next_expired = 1'b1;
                end
            end
            default:
            begin
                next_state = pwrdn_pkg::ST_MANUAL_DOWN;
            end
        endcase
        // Wake timing and ready flag.
        if (next_state != pwrdn_pkg::ST_ACTIVE)
        begin
            next_ready = 1'b0; // [RULE14]
            next_wake_cnt = '0;
        end
        else if (!ready)
        begin
            // The rail threshold normally ends the wait; the count caps it as a backstop.
            if (neg_rail_ok_i || wake_cnt >= WW'(WAKE_CYCLES - 1))
            begin
                next_ready = 1'b1; // [RULE14] [RULE9]
            end
            else
            begin
                next_wake_cnt = wake_cnt + WW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state <= pwrdn_pkg::ST_MANUAL_DOWN;
            idle_cnt <= '0;
            expired <= 1'b1;
            wake_cnt <= '0;
            ready <= 1'b0;
        end
        else
        begin
            state <= next_state;
            idle_cnt <= next_idle_cnt;
            expired <= next_expired;
            wake_cnt <= next_wake_cnt;
            ready <= next_ready;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    pwrdn_pkg::power_out_t pout;
    pwrdn_pkg::power_out_t next_pout;

    always_comb
    begin
        next_pout.pump_on = (next_state == pwrdn_pkg::ST_ACTIVE);
        next_pout.tx_enable = next_ready; // [RULE18] [RULE9]
        next_pout.inv_rx_enable = !(FIVE_RX_VARIANT &&
                                    next_state == pwrdn_pkg::ST_MANUAL_DOWN); // [RULE13] [RULE18]
        next_pout.ready = next_ready;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pout <= pwrdn_pkg::POWER_OUT_RESET;
        end
        else
        begin
            pout <= next_pout;
        end
    end

    assign line_valid_o = line_valid;
    assign ready_o = pout.ready;
    assign pump_on_o = pout.pump_on;
    assign tx_enable_o = pout.tx_enable;
    assign inv_rx_enable_o = pout.inv_rx_enable;
    assign always_on_receiver_out_enable_o = 1'b1;
    assign power_state_o = state;

endmodule : serial_port_powerdown_control

`default_nettype wire

// ==== verif/pwrdn_checker.sv ====
// Port assertions for the serial port powerdown control.
`timescale 1ns/1ps
`default_nettype none
module pwrdn_checker #(
    parameter int unsigned NUM_RX = 5
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic shutdown_override_pin_i,
    input wire logic keep_awake_pin_i,
    input wire logic [NUM_RX-1:0] rx_level_valid_i,
    input wire logic line_valid_o,
    input wire logic ready_o,
    input wire logic pump_on_o,
    input wire logic tx_enable_o,
    input wire logic inv_rx_enable_o,
    input wire logic always_on_receiver_out_enable_o,
    input wire logic [1:0] power_state_o
);
    logic [10:0] bad_run;
    logic [10:0] next_bad_run;
    logic [7:0] good_run;
    logic [7:0] next_good_run;
    always_comb
    begin
        next_bad_run = bad_run;
        next_good_run = good_run;
        if (|rx_level_valid_i)
            next_bad_run = 11'h000;
        else if (bad_run != 11'h7ff)
            next_bad_run = bad_run + 11'h001;
        if (!(|rx_level_valid_i))
            next_good_run = 8'h00;
        else if (good_run != 8'hff)
            next_good_run = good_run + 8'h01;
    end
    always_ff @(posedge clk_sys_i)
    begin
        bad_run <= rst_i ? 11'h000 : next_bad_run;
        good_run <= rst_i ? 8'h00 : next_good_run;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    property p_force_down;
        !shutdown_override_pin_i [*5] |-> power_state_o == pwrdn_pkg::ST_MANUAL_DOWN;
    endproperty
    a_force_down: assert property (p_force_down) else $error("not down while forced");
    property p_stay_on;
        (shutdown_override_pin_i && keep_awake_pin_i) [*5] |-> pump_on_o;
    endproperty
    a_stay_on: assert property (p_stay_on) else $error("down while kept awake");
    property p_pump_state;
        pump_on_o == (power_state_o == pwrdn_pkg::ST_ACTIVE);
    endproperty
    a_pump_state: assert property (p_pump_state) else $error("pump and state differ");
    property p_ready_off;
        !pump_on_o |-> !ready_o && !tx_enable_o;
    endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready while down");
    property p_wake_time;
        $rose(pump_on_o) |-> ##[0:40] ready_o;
    endproperty
    a_wake_time: assert property (p_wake_time) else $error("wake too slow");
    property p_flag_low;
        bad_run >= 11'd1510 |-> !line_valid_o;
    endproperty
    a_flag_low: assert property (p_flag_low) else $error("flag stuck high");
    property p_flag_fall;
        $fell(line_valid_o) |-> bad_run >= 11'd1495;
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag fell early");
    property p_flag_high;
        good_run >= 8'd60 |-> line_valid_o;
    endproperty
    a_flag_high: assert property (p_flag_high) else $error("flag stuck low");
    property p_inv_rx;
        inv_rx_enable_o == (power_state_o != pwrdn_pkg::ST_MANUAL_DOWN);
    endproperty
    a_inv_rx: assert property (p_inv_rx) else $error("inverting receivers wrong");
    property p_always_on;
        always_on_receiver_out_enable_o;
    endproperty
    a_always_on: assert property (p_always_on) else $error("wake receiver off");
endmodule : pwrdn_checker
bind serial_port_powerdown_control pwrdn_checker #(.NUM_RX(NUM_RX)) u_pwrdn_checker (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .shutdown_override_pin_i(shutdown_override_pin_i),
    .keep_awake_pin_i(keep_awake_pin_i),
    .rx_level_valid_i(rx_level_valid_i),
    .line_valid_o(line_valid_o),
    .ready_o(ready_o),
    .pump_on_o(pump_on_o),
    .tx_enable_o(tx_enable_o),
    .inv_rx_enable_o(inv_rx_enable_o),
    .always_on_receiver_out_enable_o(always_on_receiver_out_enable_o),
    .power_state_o(power_state_o)
);
`default_nettype wire

// ==== verif/rail_model.sv ====
// Negative charge pump rail model that reports when the rail is reached.
`timescale 1ns/1ps
`default_nettype none
module rail_model #(
    parameter int unsigned RISE_CYCLES = 5
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Pump control and rail status
    input wire logic pump_on_i,
    output logic rail_ok_o
);
    logic [7:0] count;
    logic [7:0] next_count;
    // The rail decays at once when the pump stops, so a wake never sees a stale ok.
    always_comb
    begin
        next_count = count;
        if (!pump_on_i)
            next_count = 8'h00;
        else if (count != RISE_CYCLES[7:0])
            next_count = count + 8'h01;
    end
    always_ff @(posedge clk_sys_i)
    begin
        count <= rst_i ? 8'h00 : next_count;
    end
    assign rail_ok_o = (count == RISE_CYCLES[7:0]);
endmodule : rail_model
`default_nettype wire

// ==== verif/serial_port_powerdown_control_tb.sv ====
// Self-checking bench for the serial port powerdown control.
`timescale 1ns/1ps
`default_nettype none
module serial_port_powerdown_control_tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic shutdown_override_pin_i = 1'b0;
    logic keep_awake_pin_i = 1'b0;
    logic [2:0] tx_data_i = 3'h0;
    logic [4:0] rx_data_i = 5'h00;
    logic [4:0] rx_level_valid_i = 5'h00;
    logic neg_rail_ok_i;
    logic line_valid_o, ready_o, pump_on_o, tx_enable_o, inv_rx_enable_o, always_on;
    logic [1:0] power_state_o;
    logic [1:0] last_st;
    logic last_valid;
    logic want_valid;
    logic [1:0] st_q[$];
    logic valid_q[$];
    logic [16:0] seed = 17'h1_046c;
    int errors = 0;
    int tests_run = 0;
    serial_port_powerdown_control #(.IDLE_CYCLES(200), .WAKE_CYCLES(20))
        u_serial_port_powerdown_control (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .shutdown_override_pin_i(shutdown_override_pin_i), .keep_awake_pin_i(keep_awake_pin_i),
        .tx_data_i(tx_data_i), .rx_data_i(rx_data_i), .rx_level_valid_i(rx_level_valid_i),
        .neg_rail_ok_i(neg_rail_ok_i), .line_valid_o(line_valid_o), .ready_o(ready_o),
        .pump_on_o(pump_on_o), .tx_enable_o(tx_enable_o), .inv_rx_enable_o(inv_rx_enable_o),
        .always_on_receiver_out_enable_o(always_on), .power_state_o(power_state_o));
    rail_model u_rail_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pump_on_i(pump_on_o),
        .rail_ok_o(neg_rail_ok_i));
    initial
    begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: state %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: valid flag %b expected %b", $time, got, exp);
        end
    endtask : cmp_flag
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc
    // A note left in a queue after its wait is counted as a mismatch at the end.
    task automatic expect_st(input logic [1:0] s, input int lim);
        st_q.push_back(s);
        repeat (lim) if (st_q.size() != 0) @(posedge clk_sys_i);
    endtask : expect_st
    task automatic expect_flag(input logic v, input int lim);
        valid_q.push_back(v);
        repeat (lim) if (valid_q.size() != 0) @(posedge clk_sys_i);
    endtask : expect_flag
    task automatic tally_and_finish;
        if (st_q.size() != 0 || valid_q.size() != 0)
            errors++;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // Any change without a note compares against the old value and so fails.
    always @(negedge clk_sys_i)
    begin
        if (!rst_i && power_state_o !== last_st)
            cmp(power_state_o, (st_q.size() != 0) ? st_q.pop_front() : last_st);
        if (!rst_i && line_valid_o !== last_valid)
        begin
            want_valid = (valid_q.size() != 0) ? valid_q.pop_front() : last_valid;
            cmp_flag(line_valid_o, want_valid);
        end
        last_st = power_state_o;
        last_valid = line_valid_o;
    end
    initial
    begin
        #400_000;
        errors++;
        tally_and_finish();
    end
    initial
    begin
        cyc(4);
        rst_i <= 1'b0;
        cyc(3);
        @(negedge clk_sys_i);
        cmp(power_state_o, pwrdn_pkg::ST_MANUAL_DOWN);
        @(posedge clk_sys_i);
        tx_data_i <= 3'h5;
        cyc(10);
        shutdown_override_pin_i <= 1'b1;
        keep_awake_pin_i <= 1'b1;
        expect_st(pwrdn_pkg::ST_ACTIVE, 20);
        cyc(300);
        rx_level_valid_i <= 5'h04;
        expect_flag(1'b1, 100);
        keep_awake_pin_i <= 1'b0;
        cyc(190);
        @(negedge clk_sys_i);
        cmp(power_state_o, pwrdn_pkg::ST_ACTIVE);
        @(posedge clk_sys_i);
        expect_st(pwrdn_pkg::ST_AUTO_DOWN, 40);
        for (int k = 0; k < 6; k++)
        begin
            seed = lfsr(seed);
            if (seed[0])
                tx_data_i <= tx_data_i ^ (3'h1 << (seed[2:1] % 2'd3));
            else
                rx_data_i <= rx_data_i ^ (5'h01 << (seed[4:2] % 3'd5));
            expect_st(pwrdn_pkg::ST_ACTIVE, 20);
            cyc(150);
            rx_data_i <= rx_data_i ^ (5'h01 << (seed[7:5] % 3'd5));
            cyc(150);
            @(negedge clk_sys_i);
            cmp(power_state_o, pwrdn_pkg::ST_ACTIVE);
            @(posedge clk_sys_i);
            expect_st(pwrdn_pkg::ST_AUTO_DOWN, 80);
        end
        keep_awake_pin_i <= 1'b1;
        expect_st(pwrdn_pkg::ST_ACTIVE, 20);
        cyc(250);
        @(negedge clk_sys_i);
        cmp(power_state_o, pwrdn_pkg::ST_ACTIVE);
        @(posedge clk_sys_i);
        shutdown_override_pin_i <= 1'b0;
        expect_st(pwrdn_pkg::ST_MANUAL_DOWN, 20);
        rx_level_valid_i <= 5'h00;
        expect_flag(1'b0, 1600);
        keep_awake_pin_i <= 1'b0;
        shutdown_override_pin_i <= 1'b1;
        expect_st(pwrdn_pkg::ST_AUTO_DOWN, 20);
        cyc(300);
        keep_awake_pin_i <= 1'b1;
        expect_st(pwrdn_pkg::ST_ACTIVE, 20);
        cyc(50);
        shutdown_override_pin_i <= 1'b0;
        keep_awake_pin_i <= 1'b0;
        expect_st(pwrdn_pkg::ST_MANUAL_DOWN, 20);
        shutdown_override_pin_i <= 1'b1;
        keep_awake_pin_i <= 1'b1;
        expect_st(pwrdn_pkg::ST_ACTIVE, 20);
        cyc(250);
        @(negedge clk_sys_i);
        cmp(power_state_o, pwrdn_pkg::ST_ACTIVE);
        @(posedge clk_sys_i);
        tally_and_finish();
    end
endmodule : serial_port_powerdown_control_tb
`default_nettype wire
